// File: src/pot_pkg.sv
package pot_pkg;

	// Register offsets
	localparam logic [7:0] ADDR_WIPER      = 8'h00;
	localparam logic [7:0] ADDR_ACCESS     = 8'h02;

	// Reset and select values
	localparam logic [7:0] WIPER_RESET     = 8'h80;
	localparam logic [7:0] ACCESS_RESET    = 8'h00;
	localparam logic [7:0] ACCESS_BOTH     = 8'h00;
	localparam logic [7:0] ACCESS_VOLATILE = 8'h80;
	localparam logic [7:0] NV_DEFAULT      = 8'h80;
	localparam logic [2:0] PIN_IDLE        = 3'h7;

	// Byte framing
	localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

	// Timing
	localparam int unsigned CLK_FREQ_KHZ    = 200000;
	localparam int unsigned NV_WRITE_MS     = 12;
	localparam int unsigned NV_WRITE_CYCLES = NV_WRITE_MS * CLK_FREQ_KHZ;
	localparam int unsigned POWERUP_US      = 1;
	localparam int unsigned POWERUP_CYCLES  = POWERUP_US * CLK_FREQ_KHZ / 1000;

endpackage

// File: src/nv_if.sv
`timescale 1ns/1ps
interface nv_if;
	logic       wr_req;
	logic [7:0] wr_data;
	logic       busy;
	logic       ready;
	logic       load;
	logic [7:0] value;

	modport ctrl (output wr_req, output wr_data, input busy, input ready, input load, input value);
	modport mem  (input wr_req, input wr_data, output busy, output ready, output load, output value);
endinterface

// File: src/bit_sync.sv
`timescale 1ns/1ps
module bit_sync #(
	parameter int unsigned     WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// System
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	// Data
	input  wire logic [WIDTH-1:0] i_d,
	output logic      [WIDTH-1:0] o_q
);
	logic [WIDTH-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta <= RST_VAL;
			o_q  <= RST_VAL;
		end else begin
			meta <= i_d;
			o_q  <= meta;
		end
	end
endmodule

// File: src/nv_store.sv
`timescale 1ns/1ps
module nv_store #(
	parameter int unsigned NV_WRITE_CYCLES = pot_pkg::NV_WRITE_CYCLES,
	parameter int unsigned POWERUP_CYCLES  = pot_pkg::POWERUP_CYCLES
) (
	// System
	input  wire logic i_clk,
	input  wire logic i_rst,
	// Controller side
	nv_if.mem         nv
);
	localparam int unsigned MAXC = (NV_WRITE_CYCLES > POWERUP_CYCLES) ?
		NV_WRITE_CYCLES : POWERUP_CYCLES;
	localparam int unsigned CW = $clog2(MAXC + 1);

	if (NV_WRITE_CYCLES < 1 || POWERUP_CYCLES < 1) begin : g_chk
		$error("nv_store: cycle counts must be at least one");
	end

	typedef enum logic [1:0] {NV_POWERUP, NV_IDLE, NV_WRITE} nv_state_e;

	nv_state_e   state;
	logic [CW-1:0] cnt;
	logic [7:0]  stored;
	logic [7:0]  pending;

	wire cnt_done = (cnt == CW'(1));

	// Stored value survives only until i_rst; a real cell would not
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state   <= NV_POWERUP;
			cnt     <= CW'(POWERUP_CYCLES);
			stored  <= pot_pkg::NV_DEFAULT;
			pending <= 8'h00;
		end else begin
			unique case (state)
				NV_POWERUP: begin
					cnt <= cnt - CW'(1);
					if (cnt_done) begin
						state <= NV_IDLE;
					end
				end
				NV_IDLE: begin
					if (nv.wr_req) begin
						state   <= NV_WRITE;
						cnt     <= CW'(NV_WRITE_CYCLES);
						pending <= nv.wr_data;
					end
				end
				NV_WRITE: begin
					cnt <= cnt - CW'(1);
					if (cnt_done) begin
						state  <= NV_IDLE;
						stored <= pending;
					end
				end
			endcase
		end
	end

	assign nv.busy  = (state == NV_WRITE);
	assign nv.ready = (state != NV_POWERUP);
	assign nv.load  = (state == NV_POWERUP) && cnt_done;
	assign nv.value = stored;
endmodule

// File: src/pot_wiper_i2c_slave.sv
`timescale 1ns/1ps
module pot_wiper_i2c_slave #(
	// Arbitrary device code
	parameter logic [6:0]  DEVICE_CODE     = 7'h3B,
	parameter int unsigned NV_WRITE_CYCLES = pot_pkg::NV_WRITE_CYCLES,
	parameter int unsigned POWERUP_CYCLES  = pot_pkg::POWERUP_CYCLES
) (
	// System
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// Serial link
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_sda,
	output logic            o_sda_oe,
	// Protection
	input  wire logic       i_wp_n,
	// Potentiometer side
	output logic [7:0]      o_wiper,
	output logic            o_standby
);
	typedef enum logic [3:0] {
		ST_POWERUP, ST_IDLE, ST_ID, ST_ID_ACK, ST_ADDR, ST_ADDR_ACK, ST_WDATA,
		ST_WDATA_ACK, ST_WAIT_STOP, ST_RDATA, ST_RDATA_ACK, ST_NV_BUSY, ST_IGNORE
	} state_e;

	nv_if nv ();

	nv_store #(
		.NV_WRITE_CYCLES (NV_WRITE_CYCLES),
		.POWERUP_CYCLES  (POWERUP_CYCLES)
	) u_nv (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.nv    (nv.mem)
	);

	// Link domain: MSB-first shift
	logic [7:0] link_word;

	always_ff @(posedge i_scl or posedge i_rst) begin
		if (i_rst) begin
			link_word <= 8'h00;
		end else begin
			link_word <= {link_word[6:0], i_sda};
		end
	end

	// Pin synchronisers
	logic [2:0] pins_s;

	bit_sync #(
		.WIDTH   (3),
		.RST_VAL (pot_pkg::PIN_IDLE)
	) u_sync (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_d   ({i_wp_n, i_sda, i_scl}),
		.o_q   (pins_s)
	);

	wire scl_s  = pins_s[0];
	wire sda_s  = pins_s[1];
	wire wp_ok  = pins_s[2];

	logic scl_q;
	logic sda_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	state_e     state;
	state_e     next_state;
	logic [3:0] bit_cnt;
	logic [3:0] next_bit_cnt;
	logic [7:0] addr;
	logic [7:0] access;
	logic [7:0] wiper;
	logic [7:0] nv_data;
	logic [7:0] tx;
	logic [7:0] next_tx;
	logic       rw;
	logic       nv_pending;
	logic       host_ack;
	logic       drive_low;

	// Edge and condition decode
	wire scl_rise  = scl_s & ~scl_q;
	wire scl_fall  = ~scl_s & scl_q;
	wire start_det = scl_s & scl_q & sda_q & ~sda_s;
	wire stop_det  = scl_s & scl_q & ~sda_q & sda_s;

	// Word is stable: it last moved at least half an SCL period earlier
	wire [7:0] rx  = link_word;
	wire byte_st   = (state == ST_ID) || (state == ST_ADDR) ||
		(state == ST_WDATA) || (state == ST_RDATA);
	wire byte_done = byte_st && scl_fall && (bit_cnt == pot_pkg::BITS_PER_BYTE);
	wire ack_st    = (state == ST_ID_ACK) || (state == ST_ADDR_ACK) ||
		(state == ST_WDATA_ACK) || (state == ST_RDATA_ACK);
	// deaf while powering up or writing
	wire bus_deaf  = (state == ST_POWERUP) || (state == ST_NV_BUSY);
	wire id_ok     = (rx[7:1] == DEVICE_CODE);

	wire commit    = (state == ST_WDATA) && byte_done && wp_ok;
	wire wr_wiper  = commit && (addr == pot_pkg::ADDR_WIPER);
	wire wr_access = commit && (addr == pot_pkg::ADDR_ACCESS);
	// arm NV write when select is zero
	wire arm_nv    = wr_wiper && (access == pot_pkg::ACCESS_BOTH);
	wire launch_nv = (state == ST_WAIT_STOP) && nv_pending && stop_det;

	wire [7:0] wiper_read = (access == pot_pkg::ACCESS_VOLATILE) ? wiper : nv.value;
	wire [7:0] read_value = (addr == pot_pkg::ADDR_WIPER) ? wiper_read :
		(addr == pot_pkg::ADDR_ACCESS) ? access : 8'h00;

	always_comb begin
		next_state = state;
		if (!bus_deaf && start_det) begin
			next_state = ST_ID;
		end else if (!bus_deaf && stop_det) begin
			next_state = launch_nv ? ST_NV_BUSY : ST_IDLE;
		end else begin
			unique case (state)
				ST_POWERUP: begin
					if (nv.ready) begin
						next_state = ST_IDLE;
					end
				end
				ST_NV_BUSY: begin
					if (!nv.busy) begin
						next_state = ST_IDLE;
					end
				end
				ST_IDLE, ST_IGNORE: begin
					next_state = state;
				end
				ST_ID: begin
					if (byte_done) begin
						next_state = id_ok ? ST_ID_ACK : ST_IGNORE;
					end
				end
				ST_ID_ACK: begin
					if (scl_fall) begin
						next_state = rw ? ST_RDATA : ST_ADDR;
					end
				end
				ST_ADDR: begin
					if (byte_done) begin
						next_state = ST_ADDR_ACK;
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						next_state = ST_WDATA;
					end
				end
				ST_WDATA: begin
					if (byte_done) begin
						next_state = wp_ok ? ST_WDATA_ACK : ST_IDLE;
					end
				end
				ST_WDATA_ACK: begin
					if (scl_fall) begin
						next_state = ST_WAIT_STOP;
					end
				end
				ST_WAIT_STOP: begin
					if (scl_fall) begin
						next_state = ST_IGNORE;
					end
				end
				ST_RDATA: begin
					if (byte_done) begin
						next_state = ST_RDATA_ACK;
					end
				end
				ST_RDATA_ACK: begin
					if (scl_fall) begin
						next_state = host_ack ? ST_RDATA : ST_IGNORE;
					end
				end
			endcase
		end
	end

	always_comb begin
		next_bit_cnt = bit_cnt;
		if (start_det || (next_state != state)) begin
			next_bit_cnt = 4'h0;
		end else if (byte_st && scl_rise) begin
			next_bit_cnt = bit_cnt + 4'h1;
		end
	end

	// load then shift out MSB first
	always_comb begin
		next_tx = tx;
		if ((next_state == ST_RDATA) && (state != ST_RDATA)) begin
			next_tx = read_value;
		end else if ((state == ST_RDATA) && scl_fall) begin
			next_tx = {tx[6:0], 1'b0};
		end
	end

	wire next_ack   = (next_state == ST_ID_ACK) || (next_state == ST_ADDR_ACK) ||
		(next_state == ST_WDATA_ACK);
	wire next_drive = next_ack || ((next_state == ST_RDATA) && !next_tx[7]);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state     <= ST_POWERUP;
			bit_cnt   <= 4'h0;
			tx        <= 8'h00;
			drive_low <= 1'b0;
		end else begin
			state     <= next_state;
			bit_cnt   <= next_bit_cnt;
			tx        <= next_tx;
			drive_low <= next_drive;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			addr <= 8'h00;
			rw   <= 1'b0;
		end else begin
			if ((state == ST_ID) && byte_done) begin
				rw <= rx[0];
			end
			if ((state == ST_ADDR) && byte_done) begin
				addr <= rx;
			end
		end
	end

	// sample master ack on ninth rise
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			host_ack <= 1'b0;
		end else if ((state == ST_RDATA_ACK) && scl_rise) begin
			host_ack <= ~sda_s;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wiper <= pot_pkg::WIPER_RESET;
		end else if (nv.load) begin
			wiper <= nv.value;
		end else if (wr_wiper) begin
			wiper <= rx;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			access <= pot_pkg::ACCESS_RESET;
		end else if (wr_access) begin
			access <= rx;
		end
	end

	// pending NV copy only with select zero
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			nv_pending <= 1'b0;
			nv_data    <= 8'h00;
		end else if (arm_nv) begin
			nv_pending <= 1'b1;
			nv_data    <= rx;
		end else if ((next_state != ST_WDATA_ACK) && (next_state != ST_WAIT_STOP)) begin
			nv_pending <= 1'b0;
		end
	end

	assign nv.wr_req  = launch_nv;
	assign nv.wr_data = nv_data;

	// open drain, released unless driving low
	assign o_sda     = 1'b0;
	assign o_sda_oe  = drive_low;
	assign o_wiper   = wiper;
	assign o_standby = (state == ST_IDLE);

	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_id_match;
		(state == ST_ID) && byte_done && id_ok;
	endsequence

	sequence s_id_miss;
		(state == ST_ID) && byte_done && !id_ok && !start_det && !stop_det;
	endsequence

	AST_SDA_FREE_POWERUP: assert property (state == ST_POWERUP |-> !o_sda_oe)
		else $error("SDA driven during power-up");
	AST_NV_QUIET: assert property (nv.busy |-> !o_sda_oe && state == ST_NV_BUSY)
		else $error("Bus touched during NV write");
	AST_START_IGNORED: assert property ((bus_deaf && start_det) |=> state != ST_ID)
		else $error("START accepted while deaf");
	AST_ID_ACK: assert property (s_id_match |=> o_sda_oe && state == ST_ID_ACK)
		else $error("Valid ID not acknowledged");
	AST_BAD_ID: assert property (s_id_miss |=> state == ST_IGNORE && !o_sda_oe)
		else $error("Foreign ID answered");
	AST_WP_NO_ACK: assert property (
		((state == ST_WDATA) && byte_done && !wp_ok && !start_det && !stop_det)
		|=> (state == ST_IDLE) && !o_sda_oe && (o_wiper == $past(o_wiper)))
		else $error("Inhibited write acknowledged or stored");
	AST_WIPER_COMMIT: assert property (
		(wr_wiper && !nv.load) |=> o_wiper == $past(rx))
		else $error("Wiper not updated on last falling edge");
	AST_NV_LAUNCH: assert property (launch_nv |=> nv.busy ##1 state == ST_NV_BUSY)
		else $error("NV cycle not launched on STOP");
	AST_VOL_STOP: assert property (
		(stop_det && !bus_deaf && !launch_nv && !start_det) |=> state == ST_IDLE)
		else $error("STOP did not return to standby");
	AST_ACK_LEN: assert property (
		((state == ST_ADDR) && byte_done && !start_det && !stop_det)
		|=> o_sda_oe throughout (state == ST_ADDR_ACK)[*2])
		else $error("Address ack not held");
	AST_DRIVE_WINDOW: assert property (
		o_sda_oe |-> (ack_st && (state != ST_RDATA_ACK)) || (state == ST_RDATA))
		else $error("SDA driven outside ack or read bit");
	AST_EXTRA_PULSE: assert property (
		((state == ST_WAIT_STOP) && scl_fall) |=> (state == ST_IGNORE) && !nv_pending)
		else $error("Extra clock pulse kept the NV copy");
endmodule

// File: sim/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
	// Bus lines
	output logic      o_scl,
	output logic      o_sda_low,
	input  wire logic i_sda
);
	// Clock idles high between frames
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	task automatic start();
		#20 o_sda_low = 1'b0;
		#20 o_scl = 1'b1;
		#40 o_sda_low = 1'b1;
		#40 o_scl = 1'b0;
	endtask

	task automatic bit_io(input logic b, output logic s);
		#20 o_sda_low = !b;
		#20 o_scl = 1'b1;
		#20 s = i_sda;
		#20 o_scl = 1'b0;
	endtask

	task automatic send(input logic [7:0] b, output logic nack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
		end
		bit_io(1'b1, nack);
	endtask

	task automatic recv(output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
	endtask

	task automatic stop();
		#20 o_sda_low = 1'b1;
		#20 o_scl = 1'b1;
		#40 o_sda_low = 1'b0;
		#40;
	endtask

	// one bit: read ack or stray pulse
	task automatic clock_bit(input logic b);
		logic s;
		bit_io(b, s);
	endtask
endmodule

// File: sim/pot_wiper_i2c_slave_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
	$display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module pot_wiper_i2c_slave_tb;
	// Arbitrary code
	localparam logic [6:0] DEV = 7'h3B;
	localparam int unsigned NVC = 400;

	logic       i_clk;
	logic       i_rst;
	logic       i_wp_n;
	logic       scl;
	logic       m_low;
	logic       sda_oe;
	logic       sda_val;
	logic       standby;
	logic [7:0] wiper;
	logic [7:0] obs;
	logic [7:0] v;
	logic [7:0] e;
	wire logic  sda;
	int         fail_count;
	int         tests_run;
	integer     seed;
	logic [7:0] exp_q[$];
	event       obs_ev;

	// Pull-up: a released line reads high
	assign sda = (m_low || (sda_oe && !sda_val)) ? 1'b0 : 1'b1;

	pot_wiper_i2c_slave #(.DEVICE_CODE(DEV), .NV_WRITE_CYCLES(NVC), .POWERUP_CYCLES(40)) u_dut (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_scl     (scl),
		.i_sda     (sda),
		.o_sda     (sda_val),
		.o_sda_oe  (sda_oe),
		.i_wp_n    (i_wp_n),
		.o_wiper   (wiper),
		.o_standby (standby)
	);

	i2c_master_model u_master (
		.o_scl     (scl),
		.o_sda_low (m_low),
		.i_sda     (sda)
	);

	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	// Oldest note against each observed bus result
	initial forever begin
		@(obs_ev);
		e = exp_q.pop_front();
		`CHK(obs, e)
	end

	task automatic tally_and_finish();
		$display("counts: %0d compared, %0d mismatched", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic test_done(input string n);
		$display("test %s finished", n);
	endtask

	task automatic do_reset();
		@(posedge i_clk) i_rst <= 1'b1;
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
	endtask

	task automatic wait_standby(input int n);
		// Realign off the sampling edge
		@(negedge i_clk);
		for (int k = 0; k < n && standby !== 1'b1; k++) @(negedge i_clk);
		if (standby !== 1'b1) begin
			fail_count++;
			$display("mismatch at %0t: standby wait expired", $time);
			tally_and_finish();
		end
	endtask

	task automatic put(input logic [7:0] b, input logic nack);
		logic a;
		exp_q.push_back({7'h00, nack});
		u_master.send(b, a);
		obs = {7'h00, a};
		-> obs_ev;
	endtask

	task automatic wr(input logic [7:0] addr, input logic [7:0] d, input logic dn);
		u_master.start();
		put({DEV, 1'b0}, 1'b0);
		put(addr, 1'b0);
		put(d, dn);
		u_master.stop();
	endtask

	task automatic rd(input logic [7:0] addr, input logic [7:0] x, input logic again = 1'b0);
		logic [7:0] d;
		u_master.start();
		put({DEV, 1'b0}, 1'b0);
		put(addr, 1'b0);
		u_master.start();
		put({DEV, 1'b1}, 1'b0);
		exp_q.push_back(x);
		u_master.recv(d);
		obs = d;
		-> obs_ev;
		if (again) begin
			u_master.clock_bit(1'b0);
			exp_q.push_back(x);
			u_master.recv(d);
			obs = d;
			-> obs_ev;
		end
		u_master.stop();
	endtask

	initial begin
		seed = 32'h48180B6E;
		i_rst = 1'b1;
		i_wp_n = 1'b1;
		do_reset();
		@(posedge i_clk);
		#1;
		`CHK(standby, 1'b0)
		`CHK(sda_oe, 1'b0)
		`CHK(wiper, 8'h80)
		// A start inside power-up goes unseen
		u_master.start();
		put({DEV, 1'b0}, 1'b1);
		u_master.stop();
		wait_standby(200);
		`CHK(wiper, 8'h80)
		test_done("power-up");
		u_master.start();
		put({~DEV, 1'b0}, 1'b1);
		u_master.stop();
		test_done("wrong code");
		wr(8'h02, 8'h80, 1'b0);
		v = 8'($random(seed));
		wr(8'h00, v, 1'b0);
		`CHK(wiper, v)
		`CHK(standby, 1'b1)
		rd(8'h00, v, 1'b1);
		rd(8'h02, 8'h80);
		test_done("volatile");
		wr(8'h02, 8'h00, 1'b0);
		rd(8'h00, 8'h80);
		// stray pulse drops the NV copy
		u_master.start();
		put({DEV, 1'b0}, 1'b0);
		put(8'h00, 1'b0);
		put(8'h5A, 1'b0);
		u_master.clock_bit(1'b1);
		u_master.stop();
		`CHK(standby, 1'b1)
		`CHK(wiper, 8'h5A)
		rd(8'h00, 8'h80);
		v = 8'($random(seed));
		wr(8'h00, v, 1'b0);
		repeat (4) @(negedge i_clk);
		`CHK(standby, 1'b0)
		// Bus is dead while the store runs
		u_master.start();
		put({DEV, 1'b0}, 1'b1);
		u_master.stop();
		wait_standby(NVC + 200);
		rd(8'h00, v);
		test_done("nonvolatile");
		@(posedge i_clk) i_wp_n <= 1'b0;
		@(negedge i_clk);
		wr(8'h00, ~v, 1'b1);
		`CHK(wiper, v)
		`CHK(standby, 1'b1)
		@(posedge i_clk) i_wp_n <= 1'b1;
		test_done("write inhibit");
		do_reset();
		wait_standby(200);
		`CHK(wiper, 8'h80)
		rd(8'h00, 8'h80);
		test_done("second reset");
		tally_and_finish();
	end
endmodule
